// ===== cpmsc_pkg.sv
// shared constants, types and decode function of the charge-port mode control
package cpmsc_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned V1P2_HOLD_US = 100;
  localparam int unsigned V1P2_HOLD_CYCLES = V1P2_HOLD_US * CLK_MHZ;
  localparam int unsigned HOLD_W = 16;

  // ---------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_HOLD = 4'h8;
  localparam logic [3:0] ADDR_COUNT = 4'hc;

  // control register fields
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_MODE_LSB = 1;
  localparam int unsigned MODE_W = 3;
  localparam logic [MODE_W-1:0] CTRL_MODE_RST = 3'h0;
  localparam logic CTRL_EN_RST = 1'b0;

  // status register fields
  localparam int unsigned ST_PWR_BIT = 0;
  localparam int unsigned ST_DATA_BIT = 1;
  localparam int unsigned ST_SCHEME_LSB = 2;
  localparam int unsigned ST_DISCH_BIT = 6;
  localparam int unsigned ST_ILIM_BIT = 7;

  localparam int unsigned CNT_W = 16;

  // ---------------------------------------------------------------
  // mode select codes
  // ---------------------------------------------------------------
  localparam logic [MODE_W-1:0] SEL_SDP = 3'h1;
  localparam logic [MODE_W-1:0] SEL_CDP = 3'h2;
  localparam logic [MODE_W-1:0] SEL_DCP = 3'h3;
  localparam logic [MODE_W-1:0] SEL_CLIENT = 3'h4;

  typedef enum logic [4:0] {
    CPMSC_MODE_OFF = 5'b00001,
    CPMSC_MODE_SDP = 5'b00010,
    CPMSC_MODE_CDP = 5'b00100,
    CPMSC_MODE_DCP = 5'b01000,
    CPMSC_MODE_CLIENT = 5'b10000
  } cpmsc_mode_t;

  // auto-detect states, also the scheme pattern shown in status
  typedef enum logic [3:0] {
    CPMSC_ST_DIVIDER = 4'b0001,
    CPMSC_ST_DIV_LOCK = 4'b0010,
    CPMSC_ST_V1P2 = 4'b0100,
    CPMSC_ST_SHORTED = 4'b1000
  } cpmsc_state_t;

  // select code to mode; unused codes behave as off
  function automatic cpmsc_mode_t cpmsc_decode(input logic [MODE_W-1:0] sel);
    cpmsc_mode_t m;
    m = CPMSC_MODE_OFF;
    if (sel == SEL_SDP) begin
      m = CPMSC_MODE_SDP;
    end else if (sel == SEL_CDP) begin
      m = CPMSC_MODE_CDP;
    end else if (sel == SEL_DCP) begin
      m = CPMSC_MODE_DCP;
    end else if (sel == SEL_CLIENT) begin
      m = CPMSC_MODE_CLIENT;
    end
    return m;
  endfunction

endpackage

// ===== cpmsc_if.sv
// internal carrier between the top and its switch and detect modules
`timescale 1ns/1ps
`default_nettype none
interface cpmsc_if;
  import cpmsc_pkg::*;
  logic enable;
  logic [MODE_W-1:0] mode_sel;
  logic discharge_active;
  cpmsc_state_t scheme;
  logic next_power_on;
  logic next_data_on;

  modport ctrl (output enable, output mode_sel, output discharge_active,
                input scheme, input next_power_on, input next_data_on);
  modport sw (input enable, input mode_sel, input discharge_active,
              output next_power_on, output next_data_on);
  modport det (input enable, input mode_sel, output scheme);
endinterface
`default_nettype wire

// ===== cpmsc_switch_dec.sv
// decides power switch and data pass switch from mode, enable, discharge
`timescale 1ns/1ps
`default_nettype none
module cpmsc_switch_dec (
  // control carrier
  cpmsc_if.sw bus
);
  import cpmsc_pkg::*;

  cpmsc_mode_t mode;

  // ---------------------------------------------------------------
  // switch decision
  // ---------------------------------------------------------------
  // current limit is deliberately not an input here
  always_comb begin
    mode = cpmsc_decode(bus.mode_sel);
    bus.next_power_on = 1'b0;
    bus.next_data_on = 1'b0;
    if (bus.enable) begin
      // data passes in sdp, cdp (handshake too) and client
      bus.next_data_on = (mode == CPMSC_MODE_SDP) ||
                         (mode == CPMSC_MODE_CDP) ||
                         (mode == CPMSC_MODE_CLIENT);
      // client keeps vbus off to avoid a power conflict
      bus.next_power_on = (mode == CPMSC_MODE_SDP) ||
                          (mode == CPMSC_MODE_CDP) ||
                          (mode == CPMSC_MODE_DCP);
    end
    // dcp never passes data; covered since dcp is not listed
    if (bus.discharge_active) begin
      bus.next_data_on = 1'b0;
      bus.next_power_on = 1'b0;
    end
  end

endmodule
`default_nettype wire

// ===== cpmsc_auto_detect.sv
// automatic dedicated-charging scheme detector
`timescale 1ns/1ps
`default_nettype none
module cpmsc_auto_detect (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // control carrier
  cpmsc_if.det bus,
  // attached device observations
  input wire logic dev_divider_ok,
  input wire logic dev_shorted_req,
  input wire logic dev_line_released,
  // timing and events
  input wire logic [cpmsc_pkg::HOLD_W-1:0] hold_cycles,
  output logic shorted_entry
);
  import cpmsc_pkg::*;

  cpmsc_state_t state;
  cpmsc_state_t next_state;
  logic [HOLD_W-1:0] count;
  logic [HOLD_W-1:0] next_count;
  logic active;

  assign bus.scheme = state;

  // ---------------------------------------------------------------
  // scheme sequence
  // ---------------------------------------------------------------
  always_comb begin
    active = bus.enable && (cpmsc_decode(bus.mode_sel) == CPMSC_MODE_DCP);
    next_state = state;
    next_count = count;
    shorted_entry = 1'b0;
    if (!active) begin
      next_state = CPMSC_ST_DIVIDER; // restart on divider
      next_count = '0;
    end else begin
      case (state)
        CPMSC_ST_DIVIDER: begin
          if (dev_divider_ok) begin
            next_state = CPMSC_ST_DIV_LOCK;
          end else if (dev_shorted_req) begin
            next_state = CPMSC_ST_V1P2;
            next_count = '0;
          end
        end
        CPMSC_ST_DIV_LOCK: begin
          next_state = CPMSC_ST_DIV_LOCK; // no more transitions
        end
        CPMSC_ST_V1P2: begin
          // brief 1.2 v phase, then shorted
          if (count >= hold_cycles - 1'b1 || hold_cycles == '0) begin
            next_state = CPMSC_ST_SHORTED;
            shorted_entry = 1'b1;
          end else begin
            next_count = count + 1'b1;
          end
        end
        CPMSC_ST_SHORTED: begin
          if (dev_line_released) begin
            next_state = CPMSC_ST_DIVIDER;
          end
        end
        default: begin
          next_state = CPMSC_ST_DIVIDER;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= CPMSC_ST_DIVIDER;
      count <= '0;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

endmodule
`default_nettype wire

// ===== cpmsc_top.sv
// top of the charge-port mode control: avalon registers and switch outputs
`timescale 1ns/1ps
`default_nettype none
module cpmsc_top #(
  parameter int unsigned HOLD_CYCLES = cpmsc_pkg::V1P2_HOLD_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [cpmsc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // analog side observations
  input wire logic discharge_active,
  input wire logic current_limit_active,
  input wire logic dev_divider_ok,
  input wire logic dev_shorted_req,
  input wire logic dev_line_released,
  // switch enables
  output logic power_sw_en,
  output logic data_sw_en,
  // data-line charging scheme drive
  output logic divider_2p7v_scheme,
  output logic v1p2_scheme,
  output logic shorted_scheme
);
  import cpmsc_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  cpmsc_if link ();

  logic ctrl_en;
  logic next_ctrl_en;
  logic [MODE_W-1:0] ctrl_mode;
  logic [MODE_W-1:0] next_ctrl_mode;
  logic [HOLD_W-1:0] hold;
  logic [HOLD_W-1:0] next_hold;
  logic [CNT_W-1:0] shorted_count;
  logic [CNT_W-1:0] next_shorted_count;
  logic shorted_entry;

  logic next_waitrequest;
  logic [31:0] next_readdata;
  logic req;
  logic commit;

  logic next_power_sw_en;
  logic next_data_sw_en;
  logic next_divider;
  logic next_v1p2;
  logic next_shorted;

  // ---------------------------------------------------------------
  // carrier wiring
  // ---------------------------------------------------------------
  // software-held controls feed both deciders
  assign link.enable = ctrl_en;
  assign link.mode_sel = ctrl_mode;
  assign link.discharge_active = discharge_active;

  // ---------------------------------------------------------------
  // sub blocks
  // ---------------------------------------------------------------
  cpmsc_switch_dec u_switch (
    .bus (link.sw)
  );

  cpmsc_auto_detect u_detect (
    .ref_clk (ref_clk),
    .rst_n (rst_n),
    .bus (link.det),
    .dev_divider_ok (dev_divider_ok),
    .dev_shorted_req (dev_shorted_req),
    .dev_line_released (dev_line_released),
    .hold_cycles (hold),
    .shorted_entry (shorted_entry)
  );

  // ---------------------------------------------------------------
  // read data mux
  // ---------------------------------------------------------------
  // address decode as an if chain; unmapped reads return zero
  function automatic logic [31:0] read_mux(input logic [ADDR_W-1:0] a,
                                           input logic [31:0] st);
    logic [31:0] d;
    d = '0;
    if (a == ADDR_CTRL) begin
      d[CTRL_EN_BIT] = ctrl_en;
      d[CTRL_MODE_LSB +: MODE_W] = ctrl_mode;
    end else if (a == ADDR_STATUS) begin
      d = st;
    end else if (a == ADDR_HOLD) begin
      d[HOLD_W-1:0] = hold;
    end else if (a == ADDR_COUNT) begin
      d[CNT_W-1:0] = shorted_count;
    end
    return d;
  endfunction

  // ---------------------------------------------------------------
  // bus handshake
  // ---------------------------------------------------------------
  // waitrequest idles high and drops for exactly one cycle per access;
  // that costs a cycle but keeps both bus outputs straight from flops
  always_comb begin
    logic [31:0] st;
    st = '0;
    st[ST_PWR_BIT] = power_sw_en;
    st[ST_DATA_BIT] = data_sw_en;
    st[ST_SCHEME_LSB +: 4] = link.scheme;
    st[ST_DISCH_BIT] = discharge_active;
    st[ST_ILIM_BIT] = current_limit_active;
    req = avs_read || avs_write;
    commit = req && !avs_waitrequest;
    next_waitrequest = 1'b1;
    next_readdata = avs_readdata;
    if (req && avs_waitrequest) begin
      next_waitrequest = 1'b0;
      next_readdata = read_mux(avs_address, st);
    end else if (commit) begin
      next_readdata = '0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end else begin
      avs_waitrequest <= next_waitrequest;
      avs_readdata <= next_readdata;
    end
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  // writes land only on the edge where waitrequest is seen low
  always_comb begin
    next_ctrl_en = ctrl_en;
    next_ctrl_mode = ctrl_mode;
    next_hold = hold;
    next_shorted_count = shorted_count;
    if (commit && avs_write) begin
      if (avs_address == ADDR_CTRL) begin
        next_ctrl_en = avs_writedata[CTRL_EN_BIT];
        next_ctrl_mode = avs_writedata[CTRL_MODE_LSB +: MODE_W];
      end else if (avs_address == ADDR_HOLD) begin
        next_hold = avs_writedata[HOLD_W-1:0];
      end else if (avs_address == ADDR_COUNT) begin
        next_shorted_count = '0;
      end
    end
    // a new shorted entry wins over a clear in the same cycle
    if (shorted_entry) begin
      next_shorted_count = shorted_count + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_en <= CTRL_EN_RST;
      ctrl_mode <= CTRL_MODE_RST;
      hold <= HOLD_CYCLES[HOLD_W-1:0];
      shorted_count <= '0;
    end else begin
      ctrl_en <= next_ctrl_en;
      ctrl_mode <= next_ctrl_mode;
      hold <= next_hold;
      shorted_count <= next_shorted_count;
    end
  end

  // ---------------------------------------------------------------
  // switch and scheme outputs
  // ---------------------------------------------------------------
  // scheme drive is only live in dcp; discharge silences it too
  always_comb begin
    next_power_sw_en = link.next_power_on;
    next_data_sw_en = link.next_data_on;
    next_divider = 1'b0;
    next_v1p2 = 1'b0;
    next_shorted = 1'b0;
    if (ctrl_en && !discharge_active &&
        cpmsc_decode(ctrl_mode) == CPMSC_MODE_DCP) begin
      // divider shown both while searching and when locked
      next_divider = (link.scheme == CPMSC_ST_DIVIDER) ||
                     (link.scheme == CPMSC_ST_DIV_LOCK);
      next_v1p2 = (link.scheme == CPMSC_ST_V1P2);
      next_shorted = (link.scheme == CPMSC_ST_SHORTED);
    end
  end

  // registered enables, off from reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_sw_en <= 1'b0;
      data_sw_en <= 1'b0;
      divider_2p7v_scheme <= 1'b0;
      v1p2_scheme <= 1'b0;
      shorted_scheme <= 1'b0;
    end else begin
      power_sw_en <= next_power_sw_en;
      data_sw_en <= next_data_sw_en;
      divider_2p7v_scheme <= next_divider;
      v1p2_scheme <= next_v1p2;
      shorted_scheme <= next_shorted;
    end
  end

endmodule
`default_nettype wire

// ===== cpmsc_top_checker.sv
// concurrent checks on the ports of the charge-port mode control
`timescale 1ns/1ps
`default_nettype none
module cpmsc_top_checker #(
  parameter int unsigned HOLD_CYCLES = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register bus
  input wire logic [cpmsc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // analog side
  input wire logic discharge_active,
  input wire logic current_limit_active,
  input wire logic dev_divider_ok,
  input wire logic dev_shorted_req,
  input wire logic dev_line_released,
  // switch and scheme outputs
  input wire logic power_sw_en,
  input wire logic data_sw_en,
  input wire logic divider_2p7v_scheme,
  input wire logic v1p2_scheme,
  input wire logic shorted_scheme
);
  import cpmsc_pkg::*;
  // ---------------------------------------------------------------
  // mirror of the control word
  // ---------------------------------------------------------------
  logic [3:0] ctl_q;
  logic [3:0] next_ctl_q;
  logic [2:0] md;
  logic exp_pwr, exp_data, dcp_q;
  // only a committed write moves the mirror, as in the slave
  always_comb begin
    next_ctl_q = ctl_q;
    if (avs_write && !avs_waitrequest && avs_address == ADDR_CTRL) begin
      next_ctl_q = avs_writedata[3:0];
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_q <= 4'h0;
    end else begin
      ctl_q <= next_ctl_q;
    end
  end
  // expected switch states; unused codes count as off
  assign md = ctl_q[3:1];
  assign dcp_q = ctl_q[0] && md == SEL_DCP;
  assign exp_pwr = ctl_q[0] && !discharge_active
    && (md == SEL_SDP || md == SEL_CDP || md == SEL_DCP);
  assign exp_data = ctl_q[0] && !discharge_active
    && (md == SEL_SDP || md == SEL_CDP || md == SEL_CLIENT);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence seq_enter_v1p2;
    $rose(v1p2_scheme);
  endsequence
  sequence seq_hold_v1p2;
    (v1p2_scheme && power_sw_en) [*2];
  endsequence
  sequence seq_div_accept;
    (divider_2p7v_scheme && dev_divider_ok && dcp_q) [*3];
  endsequence
  chk_data_mode: assert property (
    data_sw_en == $past(exp_data)) else $error("data switch state wrong");
  chk_power_mode: assert property (
    power_sw_en == $past(exp_pwr)) else $error("power switch state wrong");
  chk_disch_open: assert property (
    discharge_active |=> !data_sw_en && !power_sw_en)
    else $error("switch on during discharge");
  chk_client_mode: assert property (
    ctl_q[0] && md == SEL_CLIENT && !discharge_active
    |=> data_sw_en && !power_sw_en) else $error("client mode switches wrong");
  chk_ilim_keep: assert property (
    current_limit_active && exp_data |=> data_sw_en)
    else $error("current limit opened data switch");
  chk_start_div: assert property (
    $rose(dcp_q) && !dev_shorted_req && !discharge_active
    |-> ##[1:3] divider_2p7v_scheme)
    else $error("detection did not start in divider scheme");
  chk_shorted_seq: assert property (
    seq_enter_v1p2 |-> seq_hold_v1p2 ##[1:20] shorted_scheme && power_sw_en)
    else $error("shorted mode not reached after 1.2 V phase");
  chk_shorted_hold: assert property (
    shorted_scheme && $past(dcp_q) && dcp_q && !discharge_active
    && !$past(dev_line_released)
    |=> shorted_scheme) else $error("shorted mode left without release");
  chk_div_lock: assert property (
    seq_div_accept |=> divider_2p7v_scheme)
    else $error("divider state left after acceptance");
endmodule
`default_nettype wire

// ===== cpmsc_dev_model.sv
// attached portable device model reacting to the presented schemes
`timescale 1ns/1ps
`default_nettype none
module cpmsc_dev_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // kind of device the bench wants
  input wire logic want_div,
  input wire logic want_short,
  input wire logic want_release,
  // schemes seen on the lines
  input wire logic divider_2p7v_scheme,
  input wire logic shorted_scheme,
  // device reactions
  output logic dev_divider_ok,
  output logic dev_shorted_req,
  output logic dev_line_released
);
  logic armed;
  logic next_armed, next_ok, next_req, next_rel;
  // only the usb 2.0 pair is modelled; super-speed lanes bypass
  // a device answers only a scheme it sees; one shorted entry per arming
  always_comb begin
    next_armed = want_short ? (armed && !shorted_scheme) : 1'b1;
    next_ok = want_div && divider_2p7v_scheme;
    next_req = want_short && next_armed
      && (divider_2p7v_scheme || dev_shorted_req);
    next_rel = want_release && shorted_scheme;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      armed <= 1'b1;
      dev_divider_ok <= 1'b0;
      dev_shorted_req <= 1'b0;
      dev_line_released <= 1'b0;
    end else begin
      armed <= next_armed;
      dev_divider_ok <= next_ok;
      dev_shorted_req <= next_req;
      dev_line_released <= next_rel;
    end
  end
endmodule
`default_nettype wire

// ===== testbench.sv
// self-checking bench for the charge-port mode control
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cpmsc_pkg::*;
  // ---------------------------------------------------------------
  // signals and rows
  // ---------------------------------------------------------------
  localparam int unsigned HOLD_SIM = 4;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, power_sw_en, data_sw_en;
  logic discharge_active = 1'b0;
  logic current_limit_active = 1'b0;
  logic want_div = 1'b0;
  logic want_short = 1'b0;
  logic want_release = 1'b0;
  logic dev_divider_ok, dev_shorted_req, dev_line_released;
  logic divider_2p7v_scheme, v1p2_scheme, shorted_scheme;
  logic [2:0] sch;
  int bad_count = 0;
  int checks_done = 0;
  // row: en, mode[2:0], discharge, ilim, power, data
  logic [7:0] rows [11] = '{8'h10, 8'h93, 8'ha3, 8'hb2, 8'hc1, 8'h80,
    8'ha8, 8'hb8, 8'h97, 8'h40, 8'hf0};
  assign sch = {shorted_scheme, v1p2_scheme, divider_2p7v_scheme};
  // free-running 100 MHz clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  cpmsc_top #(.HOLD_CYCLES(HOLD_SIM)) DUT (.ref_clk(ref_clk),
    .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .discharge_active(discharge_active),
    .current_limit_active(current_limit_active),
    .dev_divider_ok(dev_divider_ok), .dev_shorted_req(dev_shorted_req),
    .dev_line_released(dev_line_released), .power_sw_en(power_sw_en),
    .data_sw_en(data_sw_en), .divider_2p7v_scheme(divider_2p7v_scheme),
    .v1p2_scheme(v1p2_scheme), .shorted_scheme(shorted_scheme));
  cpmsc_dev_model u_dev (.ref_clk(ref_clk), .rst_n(rst_n),
    .want_div(want_div), .want_short(want_short),
    .want_release(want_release), .divider_2p7v_scheme(divider_2p7v_scheme),
    .shorted_scheme(shorted_scheme), .dev_divider_ok(dev_divider_ok),
    .dev_shorted_req(dev_shorted_req),
    .dev_line_released(dev_line_released));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic complete_run();
    $display("mismatches %0d checks %0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) begin
      bad_count++;
      complete_run();
    end
  endtask
  task automatic chk_rd(input logic [3:0] a, input logic [31:0] m,
                        input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    cmp(rd & m, exp);
  endtask
  // bounded wait for one scheme pattern on the lines
  task automatic wait_sch(input logic [2:0] want);
    int n;
    n = 0;
    while (sch !== want && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    cmp({29'h0, sch}, {29'h0, want});
    if (n >= 200) begin
      complete_run();
    end
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk);
    cmp({29'h0, power_sw_en, data_sw_en, avs_waitrequest}, 32'h1);
    rst_n <= 1'b1;
    chk_rd(ADDR_CTRL, 32'hffffffff, 32'h0);
    chk_rd(ADDR_HOLD, 32'hffff, HOLD_SIM);
    // only the low half of a hold write lands; then restore the sim value
    bus(1'b1, ADDR_HOLD, 32'h0003_0007);
    chk_rd(ADDR_HOLD, 32'hffffffff, 32'h7);
    bus(1'b1, ADDR_HOLD, HOLD_SIM);
    chk_rd(ADDR_COUNT, 32'hffff, 32'h0);
    bus(1'b1, 4'h2, 32'hffffffff);
    chk_rd(4'h2, 32'hffffffff, 32'h0);
    // mode table, with discharge and current limit beside it
    foreach (rows[i]) begin
      discharge_active <= rows[i][3];
      current_limit_active <= rows[i][2];
      bus(1'b1, ADDR_CTRL, {28'h0, rows[i][6:4], rows[i][7]});
      repeat (2) @(posedge ref_clk);
      cmp({30'h0, power_sw_en, data_sw_en}, rows[i][1:0]);
      chk_rd(ADDR_STATUS, 32'hc3,
        {24'h0, rows[i][2], rows[i][3], 4'h0, rows[i][0], rows[i][1]});
    end
    // shorted-mode device, then line release
    want_short <= 1'b1;
    bus(1'b1, ADDR_CTRL, {28'h0, SEL_DCP, 1'b1});
    wait_sch(3'h1);
    wait_sch(3'h2);
    wait_sch(3'h4);
    cmp({31'h0, power_sw_en}, 32'h1);
    chk_rd(ADDR_COUNT, 32'hffff, 32'h1);
    repeat (20) @(posedge ref_clk);
    cmp({29'h0, sch}, 32'h4);
    want_release <= 1'b1;
    wait_sch(3'h1);
    want_release <= 1'b0;
    want_short <= 1'b0;
    bus(1'b1, ADDR_COUNT, 32'h0);
    chk_rd(ADDR_COUNT, 32'hffff, 32'h0);
    // divider device locks even when a shorted request follows
    bus(1'b1, ADDR_CTRL, 32'h0);
    want_div <= 1'b1;
    bus(1'b1, ADDR_CTRL, {28'h0, SEL_DCP, 1'b1});
    wait_sch(3'h1);
    repeat (5) @(posedge ref_clk);
    want_short <= 1'b1;
    repeat (20) @(posedge ref_clk);
    cmp({29'h0, sch}, 32'h1);
    chk_rd(ADDR_STATUS, 32'h3c, 32'h8);
    chk_rd(ADDR_COUNT, 32'hffff, 32'h0);
    want_div <= 1'b0;
    want_short <= 1'b0;
    complete_run();
  end
endmodule
bind cpmsc_top cpmsc_top_checker #(.HOLD_CYCLES(HOLD_CYCLES)) u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .discharge_active(discharge_active),
  .current_limit_active(current_limit_active),
  .dev_divider_ok(dev_divider_ok), .dev_shorted_req(dev_shorted_req),
  .dev_line_released(dev_line_released), .power_sw_en(power_sw_en),
  .data_sw_en(data_sw_en), .divider_2p7v_scheme(divider_2p7v_scheme),
  .v1p2_scheme(v1p2_scheme), .shorted_scheme(shorted_scheme));
`default_nettype wire
